/* bench/bsc_branch_skip_control_assertions.sv */
`timescale 1ns/1ps
module bsc_checker (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // Operation request
  input  wire logic             i_op_valid,
  input  wire bsc_pkg::bsc_op_t i_op,
  input  wire logic             o_op_ready,
  // Operands
  input  wire logic [15:0]      i_pc,
  input  wire logic [11:0]      i_offset,
  input  wire logic [15:0]      i_pointer,
  input  wire logic [15:0]      i_stack_pc,
  input  wire logic [4:0]       i_io_addr,
  input  wire logic [7:0]       i_status_flags,
  // Results
  input  wire logic             o_done,
  input  wire logic [15:0]      o_next_pc,
  input  wire logic [2:0]       o_cycles,
  input  wire logic             o_flags_we,
  input  wire logic [7:0]       o_status_flags,
  input  wire logic             o_push_we,
  input  wire logic             o_pop,
  input  wire logic [4:0]       o_io_addr,
  input  wire logic             o_io_bit_val
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  // Accept edge and the relative target worked out at it
  logic        acc;
  logic [15:0] rel;
  assign acc = i_op_valid && o_op_ready;
  assign rel = i_pc + {{4{i_offset[11]}}, i_offset} + 16'h0001;

  rel_jump_a: assert property (acc && i_op == bsc_pkg::OP_RELATIVE_JUMP |=>
    !o_done && o_cycles == 3'h2 && o_next_pc == $past(rel) ##1 o_done)
    else $error("relative jump target or timing wrong");
  pointer_jump_a: assert property (acc && i_op == bsc_pkg::OP_POINTER_JUMP |=>
    o_next_pc == $past(i_pointer) && !o_done ##1 o_done && !o_flags_we)
    else $error("pointer jump wrong");
  pointer_call_a: assert property (acc && i_op == bsc_pkg::OP_POINTER_INVOKE |=>
    !o_done [*2] ##1 o_done && o_push_we)
    else $error("pointer invoke wrong");
  irq_exit_a: assert property (acc && i_op == bsc_pkg::OP_IRQ_EXIT |=>
    !o_done [*3] ##1 o_done && o_pop && o_flags_we && o_status_flags[7]
    && o_next_pc == $past(i_stack_pc, 4)) else $error("irq exit wrong");
  io_set_a: assert property (acc && i_op == bsc_pkg::OP_IO_BIT_SET |=>
    o_io_addr == $past(i_io_addr) && o_io_bit_val && !o_done ##1 o_done)
    else $error("io bit set wrong");
  io_clear_a: assert property (acc && i_op == bsc_pkg::OP_IO_BIT_CLEAR |=>
    o_io_addr == $past(i_io_addr) && !o_io_bit_val && !o_done ##1 o_done)
    else $error("io bit clear wrong");
  zero_branch_a: assert property (acc && i_op == bsc_pkg::OP_BRANCH_ZERO |=>
    o_cycles == ($past(i_status_flags[1]) ? 3'h2 : 3'h1)) else $error("zero branch cost wrong");
  signed_lt_a: assert property (acc && i_op == bsc_pkg::OP_BRANCH_SIGNED_LT |=>
    o_cycles == (($past(i_status_flags[2]) ^ $past(i_status_flags[3])) ? 3'h2 : 3'h1))
    else $error("signed branch cost wrong");
  cmp_imm_a: assert property (acc && i_op == bsc_pkg::OP_COMPARE_IMMEDIATE |=>
    o_done && o_flags_we && o_cycles == 3'h1) else $error("compare immediate wrong");
endmodule

bind bsc_branch_skip_control bsc_checker bsc_checker_i (.i_clk, .i_reset, .i_op_valid, .i_op,
  .o_op_ready, .i_pc, .i_offset, .i_pointer, .i_stack_pc, .i_io_addr, .i_status_flags, .o_done,
  .o_next_pc, .o_cycles, .o_flags_we, .o_status_flags, .o_push_we, .o_pop, .o_io_addr,
  .o_io_bit_val);

/* bench/bsc_core_model.sv */
`timescale 1ns/1ps
module bsc_core_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Read port of the addressed I/O register
  input  wire logic [4:0] i_addr,
  output logic      [7:0] o_data,
  // Single-bit write port from the block
  input  wire logic       i_we,
  input  wire logic [4:0] i_waddr,
  input  wire logic [2:0] i_bit,
  input  wire logic       i_val
);
  logic [7:0] io_mem [32];

  // The core shows the addressed register at once, as the skips expect
  assign o_data = io_mem[i_addr];

  // Only the addressed bit moves, so flags elsewhere in the byte survive
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int a = 0; a < 32; a++) io_mem[a] <= 8'h5a ^ 8'(a);
    end else if (i_we) begin
      io_mem[i_waddr][i_bit] <= i_val;
    end
  end
endmodule

/* bench/test_branch_skip_control_unit.sv */
`timescale 1ns/1ps
module test_branch_skip_control_unit;
  // Design inputs, all but i_io_data given a value at time zero
  logic             i_clk = 1'b0, i_reset = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic             i_op_valid = 1'b0, i_next_two_word = 1'b0;
  logic [3:0]       i_avs_address = 4'h0, i_avs_byteenable = 4'hf;
  logic [31:0]      i_avs_writedata = 32'h0;
  bsc_pkg::bsc_op_t i_op = bsc_pkg::OP_NONE;
  logic [15:0]      i_pc = 16'h0, i_abs_addr = 16'h0, i_pointer = 16'h0, i_stack_pc = 16'h0;
  logic [11:0]      i_offset = 12'h0;
  logic [7:0]       i_reg_d = 8'h0, i_reg_r = 8'h0, i_imm = 8'h0, i_status_flags = 8'h0;
  logic [7:0]       i_io_data;
  logic [2:0]       i_bit_sel = 3'h0;
  logic [4:0]       i_io_addr = 5'h0;
  // Design outputs
  logic [31:0]      o_avs_readdata, rd;
  logic             o_avs_waitrequest, o_op_ready, o_done, o_flags_we, o_push_we, o_pop;
  logic             o_io_bit_we, o_io_bit_val;
  logic [15:0]      o_next_pc, o_push_data, r_pc, r_push;
  logic [2:0]       o_cycles, o_io_bit;
  logic [7:0]       o_status_flags, r_fl;
  logic [4:0]       o_io_addr;
  logic [3:0]       r_stb;
  logic [8:0]       r_io;
  int               fails = 0, n_compared = 0, nops = 0, cyc;

  bsc_branch_skip_control bsc_branch_skip_control_i (.*);
  bsc_core_model bsc_core_model_i (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_io_addr),
    .o_data(i_io_data), .i_we(o_io_bit_we), .i_waddr(o_io_addr), .i_bit(o_io_bit),
    .i_val(o_io_bit_val));

  // 200 MHz clock
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One op: wait for ready, then catch the done cycle and its outputs
  task automatic do_op(input bsc_pkg::bsc_op_t op, input logic [15:0] pc, a,
      input logic [11:0] off, input logic [7:0] d, r, f, input logic [2:0] b,
      input logic [4:0] io, input logic two);
    int k;
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= op;
    i_pc <= pc;
    i_abs_addr <= a;
    i_pointer <= a;
    i_stack_pc <= a;
    i_offset <= off;
    i_reg_d <= d;
    i_reg_r <= r;
    i_imm <= r;
    i_status_flags <= f;
    i_bit_sel <= b;
    i_io_addr <= io;
    i_next_two_word <= two;
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (o_op_ready !== 1'b1 && k < 20);
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    cyc = 0;
    for (k = 1; k <= 8 && cyc == 0; k++) begin
      @(negedge i_clk);
      if (o_done === 1'b1) cyc = k;
    end
    if (cyc == 0) begin
      fails++;
      stop_test();
    end
    r_pc = o_next_pc;
    r_fl = o_status_flags;
    r_push = o_push_data;
    r_stb = {o_flags_we, o_push_we, o_pop, o_io_bit_we};
    r_io = {o_io_addr, o_io_bit, o_io_bit_val};
    nops++;
  endtask

  // Bus access held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] adr, input logic [31:0] wd);
    int k;
    @(posedge i_clk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= adr;
    i_avs_writedata <= wd;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_avs_waitrequest !== 1'b0 && k < 20);
    if (o_avs_waitrequest !== 1'b0) begin
      fails++;
      stop_test();
    end
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  // Jumps, invokes and exits with a negative relative offset
  task automatic t_flow();
    int         cy [8] = '{2, 2, 3, 3, 3, 4, 4, 4};
    logic [3:0] st [8] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h4, 4'h2, 4'ha};
    for (int i = 0; i < 8; i++) begin
      do_op(bsc_pkg::bsc_op_t'(6'(i + 1)), 16'h0100, 16'h4321, 12'hffc, 8'h0, 8'h0, 8'h35,
        3'h0, 5'h0, 1'b0);
      chk(cyc, cy[i]);
      chk(r_pc, (i == 0 || i == 3) ? 16'h00fd : 16'h4321);
      chk(r_stb, st[i]);
      chk(r_fl, i == 7 ? 8'hb5 : 8'h35);
      if (i >= 3 && i <= 5) chk(r_push, i == 5 ? 16'h0102 : 16'h0101);
    end
  endtask

  // Every flag branch against four flag patterns at both offset limits
  task automatic t_branch();
    int          fi [20] = '{9, 9, 1, 1, 0, 0, 0, 0, 2, 2, 8, 8, 5, 5, 6, 6, 3, 3, 7, 7};
    logic [7:0]  fv [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
    logic [19:0] pol = 20'h55995;
    logic [11:0] off;
    logic [15:0] ep;
    logic        v;
    for (int i = 0; i < 20; i++) begin
      for (int k = 0; k < 4; k++) begin
        off = k[0] ? 12'h7ff : 12'h800;
        v = fi[i] == 9 ? fv[k][3'(i + k)] : fi[i] == 8 ? fv[k][2] ^ fv[k][3] : fv[k][fi[i]];
        v = (v == pol[i]);
        do_op(bsc_pkg::bsc_op_t'(6'(i + 17)), 16'h0100, 16'h0, off, 8'h0, 8'h0, fv[k],
          3'(i + k), 5'h0, 1'b0);
        ep = v ? 16'h0101 + {{4{off[11]}}, off} : 16'h0101;
        chk(cyc, 1 + v);
        chk(r_pc, ep);
      end
    end
  endtask

  // Skip helper: step and cost are 1, 2 or 3 alike
  task automatic sk(input bsc_pkg::bsc_op_t op, input logic [7:0] d, r, input logic [2:0] b,
      input logic [4:0] io, input logic two, s);
    logic [2:0] n;
    n = s ? (two ? 3'h3 : 3'h2) : 3'h1;
    do_op(op, 16'h0200, 16'h0, 12'h0, d, r, 8'h0, b, io, two);
    chk(cyc, n);
    chk(r_pc, 16'h0200 + n);
  endtask

  // Skips; I/O register 31 holds 8'h45 after reset
  task automatic t_skip();
    sk(bsc_pkg::OP_COMPARE_SKIP_EQUAL, 8'h3c, 8'h3c, 3'h0, 5'h0, 1'b1, 1'b1);
    sk(bsc_pkg::OP_COMPARE_SKIP_EQUAL, 8'h3c, 8'h3d, 3'h0, 5'h0, 1'b1, 1'b0);
    sk(bsc_pkg::OP_SKIP_REG_BIT_CLEAR, 8'h0, 8'hfe, 3'h0, 5'h0, 1'b0, 1'b1);
    sk(bsc_pkg::OP_SKIP_REG_BIT_SET, 8'h0, 8'hfe, 3'h0, 5'h0, 1'b0, 1'b0);
    sk(bsc_pkg::OP_SKIP_REG_BIT_SET, 8'h0, 8'h80, 3'h7, 5'h0, 1'b1, 1'b1);
    sk(bsc_pkg::OP_SKIP_IO_BIT_CLEAR, 8'h0, 8'h0, 3'h1, 5'h1f, 1'b0, 1'b1);
    sk(bsc_pkg::OP_SKIP_IO_BIT_SET, 8'h0, 8'h0, 3'h1, 5'h1f, 1'b0, 1'b0);
  endtask

  // Single-bit writes at both ends of the reachable range
  task automatic t_iobit();
    do_op(bsc_pkg::OP_IO_BIT_SET, 16'h0300, 16'h0, 12'h0, 8'h0, 8'h0, 8'h0, 3'h0, 5'h00, 1'b0);
    chk(cyc, 2);
    chk({r_stb, r_io}, {4'h1, 5'h00, 3'h0, 1'b1});
    sk(bsc_pkg::OP_SKIP_IO_BIT_SET, 8'h0, 8'h0, 3'h0, 5'h00, 1'b0, 1'b1);
    do_op(bsc_pkg::OP_IO_BIT_CLEAR, 16'h0300, 16'h0, 12'h0, 8'h0, 8'h0, 8'h0, 3'h0, 5'h1f, 1'b0);
    chk(cyc, 2);
    chk({r_stb, r_io}, {4'h1, 5'h1f, 3'h0, 1'b0});
    sk(bsc_pkg::OP_SKIP_IO_BIT_CLEAR, 8'h0, 8'h0, 3'h0, 5'h1f, 1'b0, 1'b1);
    sk(bsc_pkg::OP_SKIP_IO_BIT_SET, 8'h0, 8'h0, 3'h2, 5'h1f, 1'b0, 1'b1);
  endtask

  // Compares: one cycle, flags written, other flag bits kept
  task automatic cp(input bsc_pkg::bsc_op_t op, input logic [7:0] d, r, f, e);
    do_op(op, 16'h0400, 16'h0, 12'h0, d, r, f, 3'h0, 5'h0, 1'b0);
    chk({cyc[3:0], r_stb, r_fl}, {4'h1, 4'h8, e});
  endtask

  task automatic t_cmp();
    cp(bsc_pkg::OP_COMPARE_IMMEDIATE, 8'h10, 8'h20, 8'h00, 8'h15);
    cp(bsc_pkg::OP_COMPARE_WITH_BORROW, 8'h05, 8'h05, 8'h03, 8'h35);
    cp(bsc_pkg::OP_COMPARE_WITH_BORROW, 8'h05, 8'h05, 8'h02, 8'h02);
    cp(bsc_pkg::OP_COMPARE_WITH_BORROW, 8'h05, 8'h05, 8'hc0, 8'hc0);
    cp(bsc_pkg::OP_COMPARE_REGS, 8'h80, 8'h01, 8'h00, 8'h38);
  endtask

  // Register bus: reset value, unmapped place, counters, enable gating
  task automatic t_bus();
    av(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h1);
    av(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    av(1'b0, 4'h8, 32'h0);
    chk(rd, 32'h0000_0401);
    av(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h0000_3810);
    av(1'b0, 4'hc, 32'h0);
    chk(rd, nops);
    av(1'b1, 4'h0, 32'h0);
    @(negedge i_clk);
    chk(o_op_ready, 1'b0);
    av(1'b1, 4'h0, 32'h1);
    av(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h1);
  endtask

  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    t_flow();
    t_branch();
    t_skip();
    t_iobit();
    t_cmp();
    t_bus();
    stop_test();
  end
endmodule

/* src/bsc_branch_skip_control.sv */
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "bsc_defines.svh"

module bsc_branch_skip_control (
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_reset,
  // Avalon-MM register slave
  input  wire logic [3:0]      i_avs_address,
  input  wire logic            i_avs_read,
  input  wire logic            i_avs_write,
  input  wire logic [31:0]     i_avs_writedata,
  input  wire logic [3:0]      i_avs_byteenable,
  output logic      [31:0]     o_avs_readdata,
  output logic                 o_avs_waitrequest,
  // Operation request from fetch
  input  wire logic            i_op_valid,
  input  bsc_pkg::bsc_op_t     i_op,
  output logic                 o_op_ready,
  // Operands
  input  wire logic [15:0]     i_pc,
  input  wire logic [11:0]     i_offset,
  input  wire logic [15:0]     i_abs_addr,
  input  wire logic [15:0]     i_pointer,
  input  wire logic [15:0]     i_stack_pc,
  input  wire logic [7:0]      i_reg_d,
  input  wire logic [7:0]      i_reg_r,
  input  wire logic [7:0]      i_imm,
  input  wire logic [2:0]      i_bit_sel,
  input  wire logic [4:0]      i_io_addr,
  input  wire logic [7:0]      i_io_data,
  input  wire logic            i_next_two_word,
  input  wire logic [7:0]      i_status_flags,
  // Results
  output logic                 o_done,
  output logic [15:0]          o_next_pc,
  output logic [2:0]           o_cycles,
  output logic                 o_flags_we,
  output logic [7:0]           o_status_flags,
  output logic                 o_push_we,
  output logic [15:0]          o_push_data,
  output logic                 o_pop,
  output logic                 o_io_bit_we,
  output logic [4:0]           o_io_addr,
  output logic [2:0]           o_io_bit,
  output logic                 o_io_bit_val
);

  typedef struct packed {
    logic        ctrl_enable;
    logic        bus_ack;
    logic [31:0] readdata;
    logic [15:0] next_pc;
    logic [2:0]  cycles;
    logic [7:0]  flags;
    logic        flags_we;
    logic        push_we;
    logic [15:0] push_data;
    logic        pop;
    logic        io_we;
    logic [4:0]  io_addr;
    logic [2:0]  io_bit;
    logic        io_val;
    logic [15:0] retired;
  } bsc_state_t;

  bsc_state_t s;
  bsc_state_t next_s;

  logic        tmr_load;
  logic [2:0]  tmr_count;
  logic        tmr_busy;
  logic        tmr_last;
  logic        accept;
  logic        bus_req;
  logic [15:0] pc_seq;
  logic [15:0] pc_rel;
  logic [15:0] pc_skip;
  logic [2:0]  cyc_skip;
  logic [7:0]  cmp_b;
  logic        cmp_cin;
  logic [8:0]  cmp_diff;
  logic [4:0]  cmp_half;
  logic        cmp_v;
  logic [7:0]  cmp_flags;
  logic        br_is;
  logic        br_bit;
  logic        br_pol;
  logic        sk_is;
  logic        sk_hit;

  // Holds the op for its documented cycle count
  bsc_cycle_timer #(
    .WIDTH (3)
  ) u_timer (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_load  (tmr_load),
    .i_count (tmr_count),
    .o_busy  (tmr_busy),
    .o_last  (tmr_last)
  );

  // Handshakes; a new op may be taken on the last cycle of the previous one
  assign accept            = o_op_ready & i_op_valid;
  assign o_op_ready        = s.ctrl_enable & (~tmr_busy | tmr_last);
  assign bus_req           = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = bus_req & ~s.bus_ack;

  // Program counter candidates
  assign pc_seq   = i_pc + `BSC_PC_STEP_ONE;
  assign pc_rel   = i_pc + 16'($signed(i_offset)) + `BSC_PC_STEP_ONE;
  assign pc_skip  = i_pc + (i_next_two_word ? `BSC_PC_STEP_THREE : `BSC_PC_STEP_TWO);
  assign cyc_skip = i_next_two_word ? `BSC_CYC_THREE : `BSC_CYC_TWO;

  // Subtractor shared by the three compares; result is never stored
  always_comb begin
    cmp_b   = (i_op == bsc_pkg::OP_COMPARE_IMMEDIATE) ? i_imm : i_reg_r;
    cmp_cin = (i_op == bsc_pkg::OP_COMPARE_WITH_BORROW) ?
              i_status_flags[`BSC_FLAG_C] : 1'b0;
    cmp_diff = {1'b0, i_reg_d} - {1'b0, cmp_b} - {8'h00, cmp_cin};
    cmp_half = {1'b0, i_reg_d[3:0]} - {1'b0, cmp_b[3:0]} - {4'h0, cmp_cin};
    cmp_v    = (i_reg_d[7] & ~cmp_b[7] & ~cmp_diff[7]) |
               (~i_reg_d[7] & cmp_b[7] & cmp_diff[7]);
    cmp_flags = i_status_flags;
    cmp_flags[`BSC_FLAG_C] = cmp_diff[8];
    cmp_flags[`BSC_FLAG_H] = cmp_half[4];
    cmp_flags[`BSC_FLAG_N] = cmp_diff[7];
    cmp_flags[`BSC_FLAG_V] = cmp_v;
    cmp_flags[`BSC_FLAG_S] = cmp_diff[7] ^ cmp_v;
    // With borrow, a zero result keeps Z so multi-byte compares chain
    if (i_op == bsc_pkg::OP_COMPARE_WITH_BORROW) begin
      cmp_flags[`BSC_FLAG_Z] = (cmp_diff[7:0] == 8'h00) & i_status_flags[`BSC_FLAG_Z];
    end else begin
      cmp_flags[`BSC_FLAG_Z] = (cmp_diff[7:0] == 8'h00);
    end
  end

  // Branch condition: tested flag value and the polarity that takes it
  always_comb begin
    br_is  = 1'b1;
    br_bit = 1'b0;
    br_pol = 1'b1;
    case (i_op)
      bsc_pkg::OP_BRANCH_FLAG_SET: br_bit = i_status_flags[i_bit_sel];
      bsc_pkg::OP_BRANCH_FLAG_CLEAR: begin
        br_bit = i_status_flags[i_bit_sel];
        br_pol = 1'b0;
      end
      bsc_pkg::OP_BRANCH_ZERO: br_bit = i_status_flags[`BSC_FLAG_Z];
      bsc_pkg::OP_BRANCH_NONZERO: begin
        br_bit = i_status_flags[`BSC_FLAG_Z];
        br_pol = 1'b0;
      end
      bsc_pkg::OP_BRANCH_CARRY_SET, bsc_pkg::OP_BRANCH_UNSIGNED_LT: begin
        br_bit = i_status_flags[`BSC_FLAG_C];
      end
      bsc_pkg::OP_BRANCH_CARRY_CLEAR, bsc_pkg::OP_BRANCH_UNSIGNED_GE: begin
        br_bit = i_status_flags[`BSC_FLAG_C];
        br_pol = 1'b0;
      end
      bsc_pkg::OP_BRANCH_NEGATIVE: br_bit = i_status_flags[`BSC_FLAG_N];
      bsc_pkg::OP_BRANCH_POSITIVE: begin
        br_bit = i_status_flags[`BSC_FLAG_N];
        br_pol = 1'b0;
      end
      // Uses N xor V directly rather than trusting a stored S
      bsc_pkg::OP_BRANCH_SIGNED_LT: begin
        br_bit = i_status_flags[`BSC_FLAG_N] ^ i_status_flags[`BSC_FLAG_V];
      end
      bsc_pkg::OP_BRANCH_SIGNED_GE: begin
        br_bit = i_status_flags[`BSC_FLAG_N] ^ i_status_flags[`BSC_FLAG_V];
        br_pol = 1'b0;
      end
      bsc_pkg::OP_BRANCH_HALFCARRY_SET: br_bit = i_status_flags[`BSC_FLAG_H];
      bsc_pkg::OP_BRANCH_HALFCARRY_CLEAR: begin
        br_bit = i_status_flags[`BSC_FLAG_H];
        br_pol = 1'b0;
      end
      bsc_pkg::OP_BRANCH_TBIT_SET: br_bit = i_status_flags[`BSC_FLAG_T];
      bsc_pkg::OP_BRANCH_TBIT_CLEAR: begin
        br_bit = i_status_flags[`BSC_FLAG_T];
        br_pol = 1'b0;
      end
      bsc_pkg::OP_BRANCH_OVERFLOW_SET: br_bit = i_status_flags[`BSC_FLAG_V];
      bsc_pkg::OP_BRANCH_OVERFLOW_CLEAR: begin
        br_bit = i_status_flags[`BSC_FLAG_V];
        br_pol = 1'b0;
      end
      bsc_pkg::OP_BRANCH_IRQ_ENABLED: br_bit = i_status_flags[`BSC_FLAG_I];
      bsc_pkg::OP_BRANCH_IRQ_DISABLED: begin
        br_bit = i_status_flags[`BSC_FLAG_I];
        br_pol = 1'b0;
      end
      default: br_is = 1'b0;
    endcase
  end

  // Skip condition for the compare and bit-test skips
  always_comb begin
    sk_is  = 1'b1;
    sk_hit = 1'b0;
    case (i_op)
      bsc_pkg::OP_COMPARE_SKIP_EQUAL: sk_hit = (i_reg_d == i_reg_r);
      bsc_pkg::OP_SKIP_REG_BIT_CLEAR: sk_hit = ~i_reg_r[i_bit_sel];
      bsc_pkg::OP_SKIP_REG_BIT_SET:   sk_hit = i_reg_r[i_bit_sel];
      bsc_pkg::OP_SKIP_IO_BIT_CLEAR:  sk_hit = ~i_io_data[i_bit_sel];
      bsc_pkg::OP_SKIP_IO_BIT_SET:    sk_hit = i_io_data[i_bit_sel];
      default:                        sk_is  = 1'b0;
    endcase
  end

  // Op dispatch, retire count and register slave
  always_comb begin
    next_s    = s;
    tmr_load  = accept;
    tmr_count = `BSC_CYC_ONE;
    if (accept) begin
      next_s.next_pc  = pc_seq;
      next_s.flags    = i_status_flags;
      next_s.flags_we = 1'b0;
      next_s.push_we  = 1'b0;
      next_s.push_data = pc_seq;
      next_s.pop      = 1'b0;
      next_s.io_we    = 1'b0;
      next_s.io_addr  = i_io_addr; // five-bit field reaches 0x00 to 0x1f only
      next_s.io_bit   = i_bit_sel;
      next_s.io_val   = 1'b0;
      case (i_op)
        bsc_pkg::OP_RELATIVE_JUMP: begin
          next_s.next_pc = pc_rel;
          tmr_count = `BSC_CYC_TWO;
        end
        bsc_pkg::OP_RELATIVE_INVOKE: begin
          next_s.next_pc = pc_rel;
          next_s.push_we = 1'b1;
          tmr_count = `BSC_CYC_THREE;
        end
        bsc_pkg::OP_POINTER_JUMP: begin
          next_s.next_pc = i_pointer;
          tmr_count = `BSC_CYC_TWO;
        end
        bsc_pkg::OP_POINTER_INVOKE: begin
          next_s.next_pc = i_pointer;
          next_s.push_we = 1'b1;
          tmr_count = `BSC_CYC_THREE;
        end
        bsc_pkg::OP_ABSOLUTE_JUMP: begin
          next_s.next_pc = i_abs_addr;
          tmr_count = `BSC_CYC_THREE;
        end
        bsc_pkg::OP_ABSOLUTE_INVOKE: begin
          // Return lands after the two-word instruction
          next_s.next_pc   = i_abs_addr;
          next_s.push_we   = 1'b1;
          next_s.push_data = i_pc + `BSC_PC_STEP_TWO;
          tmr_count = `BSC_CYC_FOUR;
        end
        bsc_pkg::OP_CALL_EXIT, bsc_pkg::OP_IRQ_EXIT: begin
          next_s.next_pc = i_stack_pc;
          next_s.pop     = 1'b1;
          tmr_count = `BSC_CYC_FOUR;
          if (i_op == bsc_pkg::OP_IRQ_EXIT) begin
            next_s.flags[`BSC_FLAG_I] = 1'b1;
            next_s.flags_we = 1'b1;
          end
        end
        bsc_pkg::OP_COMPARE_REGS, bsc_pkg::OP_COMPARE_IMMEDIATE,
        bsc_pkg::OP_COMPARE_WITH_BORROW: begin
          next_s.flags    = cmp_flags;
          next_s.flags_we = 1'b1;
        end
        bsc_pkg::OP_IO_BIT_SET, bsc_pkg::OP_IO_BIT_CLEAR: begin
          // Single-bit strobe keeps write-one-to-clear neighbours intact
          next_s.io_we  = 1'b1;
          next_s.io_val = (i_op == bsc_pkg::OP_IO_BIT_SET);
          tmr_count = `BSC_CYC_TWO;
        end
        default: begin
          if (br_is && (br_bit == br_pol)) begin
            next_s.next_pc = pc_rel;
            tmr_count = `BSC_CYC_TWO;
          end else if (sk_is && sk_hit) begin
            next_s.next_pc = pc_skip;
            tmr_count = cyc_skip;
          end
        end
      endcase
      next_s.cycles = tmr_count;
    end
    if (tmr_last) begin
      next_s.retired = s.retired + 16'h0001;
    end
    // One wait state: read data are latched, then presented with waitrequest low
    if (bus_req && !s.bus_ack) begin
      next_s.bus_ack  = 1'b1;
      next_s.readdata = 32'h0000_0000;
      if (i_avs_read) begin
        case (i_avs_address)
          `BSC_REG_CTRL: next_s.readdata[`BSC_CTRL_ENABLE_BIT] = s.ctrl_enable;
          `BSC_REG_STATUS: begin
            next_s.readdata[`BSC_STAT_BUSY_BIT] = tmr_busy;
            next_s.readdata[`BSC_STAT_CYC_MSB:`BSC_STAT_CYC_LSB] = s.cycles;
            next_s.readdata[`BSC_STAT_FLAGS_MSB:`BSC_STAT_FLAGS_LSB] = s.flags;
          end
          `BSC_REG_LAST_PC: next_s.readdata[15:0] = s.next_pc;
          `BSC_REG_RETIRED: next_s.readdata[15:0] = s.retired;
          default:          next_s.readdata = 32'h0000_0000;
        endcase
      end
    end else begin
      next_s.bus_ack = 1'b0;
    end
    // Write takes effect at the edge where waitrequest is low
    if (i_avs_write && s.bus_ack && (i_avs_address == `BSC_REG_CTRL) && i_avs_byteenable[0]) begin
      next_s.ctrl_enable = i_avs_writedata[`BSC_CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s             <= '0;
      s.ctrl_enable <= `BSC_CTRL_ENABLE_RST;
    end else begin
      s <= next_s;
    end
  end

  // Results stand from flops; side effects strobe on the final cycle
  assign o_avs_readdata = s.readdata;
  assign o_done         = tmr_last;
  assign o_next_pc      = s.next_pc;
  assign o_cycles       = s.cycles;
  assign o_status_flags = s.flags;
  assign o_flags_we     = tmr_last & s.flags_we;
  assign o_push_we      = tmr_last & s.push_we;
  assign o_push_data    = s.push_data;
  assign o_pop          = tmr_last & s.pop;
  assign o_io_bit_we    = tmr_last & s.io_we;
  assign o_io_addr      = s.io_addr;
  assign o_io_bit       = s.io_bit;
  assign o_io_bit_val   = s.io_val;

endmodule

/* src/bsc_cycle_timer.sv */
`timescale 1ns/1ps
`include "bsc_defines.svh"

module bsc_cycle_timer #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // Load a new count
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_count,
  // Progress
  output logic                  o_busy,
  output logic                  o_last
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } bsc_timer_state_t;

  bsc_timer_state_t s;
  bsc_timer_state_t next_s;

  // Load wins over the countdown so a new op may start on the last cycle
  always_comb begin
    next_s = s;
    if (i_load) begin
      next_s.count = i_count;
    end else if (s.count != '0) begin
      next_s.count = s.count - WIDTH'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_busy = (s.count != '0);
  assign o_last = (s.count == WIDTH'(1));

endmodule

/* src/bsc_defines.svh */
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// Cycle costs of each instruction class
`define BSC_CYC_ONE          3'h1
`define BSC_CYC_TWO          3'h2
`define BSC_CYC_THREE        3'h3
`define BSC_CYC_FOUR         3'h4

// Program counter steps in words
`define BSC_PC_STEP_ONE      16'h0001
`define BSC_PC_STEP_TWO      16'h0002
`define BSC_PC_STEP_THREE    16'h0003

// Status flag bit positions
`define BSC_FLAG_C           3'h0
`define BSC_FLAG_Z           3'h1
`define BSC_FLAG_N           3'h2
`define BSC_FLAG_V           3'h3
`define BSC_FLAG_S           3'h4
`define BSC_FLAG_H           3'h5
`define BSC_FLAG_T           3'h6
`define BSC_FLAG_I           3'h7

// Register map, byte addresses on the Avalon slave
`define BSC_REG_CTRL         4'h0
`define BSC_REG_STATUS       4'h4
`define BSC_REG_LAST_PC      4'h8
`define BSC_REG_RETIRED      4'hc

// Control register fields and reset value
`define BSC_CTRL_ENABLE_BIT  0
`define BSC_CTRL_ENABLE_RST  1'h1

// Status register field positions
`define BSC_STAT_BUSY_BIT    0
`define BSC_STAT_CYC_LSB     4
`define BSC_STAT_CYC_MSB     6
`define BSC_STAT_FLAGS_LSB   8
`define BSC_STAT_FLAGS_MSB   15

`endif

/* src/bsc_pkg.sv */
package bsc_pkg;

  // Control-flow operations presented by the fetch stage
  typedef enum logic [5:0] {
    OP_NONE,
    OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_ABSOLUTE_JUMP,
    OP_RELATIVE_INVOKE, OP_POINTER_INVOKE, OP_ABSOLUTE_INVOKE,
    OP_CALL_EXIT, OP_IRQ_EXIT,
    OP_COMPARE_SKIP_EQUAL, OP_COMPARE_REGS, OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_ZERO, OP_BRANCH_NONZERO,
    OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_UNSIGNED_GE, OP_BRANCH_UNSIGNED_LT,
    OP_BRANCH_NEGATIVE, OP_BRANCH_POSITIVE, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR,
    OP_BRANCH_TBIT_SET, OP_BRANCH_TBIT_CLEAR,
    OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED,
    OP_IO_BIT_SET, OP_IO_BIT_CLEAR
  } bsc_op_t;

endpackage
